// ### shared/sofr_map.vh
// Purpose: offsets, fields, reset values and timing counts of the option bank
// Assumes: APB byte addresses are four times the register index
// Notes:   definitions only
`ifndef SOFR_MAP_VH
`define SOFR_MAP_VH

// Register indices and byte addresses
`define SOFR_IDX_MISC      8'h94
`define SOFR_IDX_FLAGS     8'h95
`define SOFR_IDX_WAKE      8'h96
`define SOFR_IDX_CMD       8'h97
`define SOFR_ADDR_MISC     12'h250
`define SOFR_ADDR_FLAGS    12'h254
`define SOFR_ADDR_WAKE     12'h258
`define SOFR_ADDR_CMD      12'h25c

// Field positions
`define SOFR_MISC_ONEWIRE  7
`define SOFR_MISC_WDOG_LO  4
`define SOFR_MISC_CONV_LO  2
`define SOFR_MISC_TICK_LO  0
`define SOFR_FLG_LOWV      7
`define SOFR_FLG_TOUCH     5
`define SOFR_FLG_CONV      4
`define SOFR_FLG_PIN       1
`define SOFR_FLG_TICK      0
`define SOFR_CMD_UNLOCK    0
`define SOFR_CMD_WDOG_TIMEOUT_FLAG      1

// Reset values
`define SOFR_RST_MISC      8'h00
`define SOFR_RST_WAKE      8'h00

// Command codes
`define SOFR_CODE_RESET    8'h56
`define SOFR_CODE_UNLOCK   8'h65

// Watchdog periods in ms, slow-clock tick periods in cycles
`define SOFR_WDOG_MS_0     480
`define SOFR_WDOG_MS_1     240
`define SOFR_WDOG_MS_2     120
`define SOFR_WDOG_MS_3     60
`define SOFR_TICK_CYC_0    32768
`define SOFR_TICK_CYC_1    16384
`define SOFR_TICK_CYC_2    8192
`define SOFR_TICK_CYC_3    128

// Converter clock divisors
`define SOFR_CONV_DIV_0    32
`define SOFR_CONV_DIV_1    16
`define SOFR_CONV_DIV_2    8
`define SOFR_CONV_DIV_3    4

// Soft reset pulse length in core cycles
`define SOFR_SRST_CYC      4

`endif

// ### verification/sofr_option_regs_monitor.sv
// Purpose: port checks on the option bank
// Assumes: one clock, async active-low reset
// Notes:   flag copy is loaded in the same cycle as the flag
`timescale 1ns/100ps
`default_nettype none

module sofr_option_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        low_volt_det,
	input wire logic        touch_end,
	input wire logic        touch_fast_ok,
	input wire logic        conv_end,
	input wire logic        soft_reset_ff,
	input wire logic        self_program_unlock_ff,
	input wire logic [7:0]  flags_out_ff
);
	// Writes as the slave takes them
	wire wr  = psel && penable && pwrite && pstrb[0];
	wire cmd = wr && paddr == 12'h25c;
	wire flg = wr && paddr == 12'h254;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Command codes and flag set or clear
	unlock_set_a: assert property (
		cmd && pwdata[7:0] == 8'h65 |=> self_program_unlock_ff)
		else $error("unlock not set");
	unlock_clr_a: assert property (
		cmd && pwdata[7:0] != 8'h65 |=> !self_program_unlock_ff)
		else $error("unlock not cleared");
	srst_pulse_a: assert property (
		cmd && pwdata[7:0] == 8'h56 |=> soft_reset_ff [*4])
		else $error("soft reset pulse short");
	touch_set_a: assert property (
		touch_end && touch_fast_ok |-> ##[1:2] flags_out_ff[5])
		else $error("touch flag not set");
	conv_set_a: assert property (
		conv_end |-> ##[1:2] flags_out_ff[4])
		else $error("conv flag not set");
	conv_clr_a: assert property (
		flg && !pwdata[4] && !conv_end ##1 !conv_end |=> !flags_out_ff[4])
		else $error("conv flag not cleared");
	touch_clr_a: assert property (
		flg && !pwdata[5] && !touch_end ##1 !touch_end |=> !flags_out_ff[5])
		else $error("touch flag not cleared");
	lowv_flag_a: assert property (
		low_volt_det [*8] |-> flags_out_ff[7])
		else $error("low volt flag missing");

	// Main scenarios
	cover property (cmd && pwdata[7:0] == 8'h56);
	cover property (flg && pwdata[7:0] == 8'hdf);
	cover property (conv_end);
endmodule

bind sofr_option_regs sofr_option_monitor i_sofr_option_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.low_volt_det(low_volt_det), .touch_end(touch_end),
	.touch_fast_ok(touch_fast_ok), .conv_end(conv_end),
	.soft_reset_ff(soft_reset_ff),
	.self_program_unlock_ff(self_program_unlock_ff),
	.flags_out_ff(flags_out_ff));
`default_nettype wire

// ### verification/test_sofr_option_regs.sv
// Purpose: APB bench for the option bank
// Assumes: zero-wait slave, CLK_HZ gives 20 cycles a ms
// Notes:   slow clock runs free at a quarter of pclk
`timescale 1ns/100ps
`default_nettype none

module test_sofr_option_regs;
	reg         pclk = 0, presetn = 0, slow = 0;
	reg         psel = 0, penable = 0, pwrite = 0;
	reg  [11:0] paddr = 0;
	reg  [31:0] pwdata = 0, d;
	reg  [7:0]  pins = 0;
	reg  [5:0]  ev = 0;
	reg  [3:0]  lv = 0;
	wire [31:0] prdata;
	wire [7:0]  fl;
	wire [1:0]  ws, ts, cs;
	wire        pready, cen, wexp, fok, ow, wk, sr, ul, serr;
	integer     num_errors = 0, samples_checked = 0;
	integer     cyc = 0, rises = 0, n, r, wakes = 0, srh = 0;

	// Device, ms shortened to keep the run brief
	sofr_option_regs #(.CLK_HZ(20000)) i_sofr_option_regs (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata_ff(prdata), .pready(pready), .pslverr(serr),
		.slow_clk(slow), .port_one_pins(pins), .low_volt_det(lv[1]),
		.touch_end(ev[0]), .touch_fast_ok(lv[0]), .touch_start_bit(ev[2]),
		.conv_end(ev[1]), .conv_start_bit(ev[3]), .pin_change_ack(ev[4]),
		.tick_ack(ev[5]), .wdog_timeout(lv[2]), .program_area_lock(lv[3]),
		.one_wire_serial_sel_ff(ow), .wdog_period_sel_ff(ws),
		.conv_clock_div_sel_ff(cs), .tick_rate_sel_ff(ts),
		.conv_clk_en(cen), .wake_req_ff(wk), .soft_reset_ff(sr),
		.self_program_unlock_ff(ul), .flash_write_ok_ff(fok),
		.wdog_expire_ff(wexp), .flags_out_ff(fl));

	always #25 pclk = ~pclk;

	// Slow clock and hang guard
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc[0])
			slow <= ~slow;
		// Pulse outputs counted in cycles seen high
		if (wk === 1'b1)
			wakes = wakes + 1;
		if (sr === 1'b1)
			srh = srh + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			finish_test;
		end
	end
	always @(posedge slow)
		rises = rises + 1;

	task chk(input string what, input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask

	// One APB transfer, held until pready
	task apb(input w, input [11:0] a, input [7:0] v);
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h0, v};
			@(posedge pclk);
			penable <= 1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			d = prdata;
			psel <= 0;
			penable <= 0;
		end
	endtask

	// One-cycle event pulses
	task pulse(input [5:0] m);
		begin
			@(posedge pclk);
			ev <= m;
			@(posedge pclk);
			ev <= 0;
		end
	endtask

	task finish_test;
		begin
			$display("errors %0d checks %0d", num_errors, samples_checked);
			if (num_errors == 0 && samples_checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		// Reset values, unmapped word last
		for (n = 0; n < 5; n = n + 1) begin
			apb(0, 12'h250 + n * 4, 0);
			chk("rst", d | serr, 0);
		end
		// Option fields, bit 6 reads zero
		apb(1, 12'h250, 8'hf3);
		apb(0, 12'h250, 0);
		chk("misc", d, 8'hb3);
		chk("sel", {ow, ws, ts}, 5'h1f);
		// Watchdog marker spacing at 60 ms
		while (wexp !== 1'b1) @(posedge pclk);
		n = 1;
		@(posedge pclk);
		while (wexp !== 1'b1) begin
			@(posedge pclk);
			n = n + 1;
		end
		chk("wdog", n, 1200);
		// Tick spacing, cleared by write and by service
		while (fl[0] !== 1'b1) @(posedge pclk);
		apb(1, 12'h254, 8'hfe);
		repeat (3) @(posedge pclk);
		while (fl[0] !== 1'b1) @(posedge pclk);
		r = rises;
		apb(1, 12'h254, 8'hfe);
		apb(0, 12'h254, 0);
		chk("fe", d[0], 0);
		while (fl[0] !== 1'b1) @(posedge pclk);
		chk("ticks", rises - r, 128);
		pulse(6'h20);
		repeat (3) @(posedge pclk);
		chk("tack", fl[0], 0);
		// Converter strobes per code over 128 cycles
		for (n = 0; n < 4; n = n + 1) begin
			apb(1, 12'h250, {4'hb, n[1:0], 2'b11});
			repeat (40) @(posedge pclk);
			r = 0;
			repeat (128) begin
				@(posedge pclk);
				r = r + cen;
			end
			chk("conv", r, 4 << n);
			chk("csel", cs, n);
		end
		// Touch needs a fast clock; masked clears
		apb(1, 12'h254, 0);
		pulse(6'h01);
		apb(0, 12'h254, 0);
		chk("slow", d & 8'h20, 0);
		lv[0] <= 1;
		pulse(6'h03);
		apb(0, 12'h254, 0);
		chk("set", d & 8'h32, 8'h30);
		apb(1, 12'h254, 8'hdf);
		apb(0, 12'h254, 0);
		chk("df", d & 8'h32, 8'h10);
		pulse(6'h01);
		apb(1, 12'h254, 8'hef);
		apb(0, 12'h254, 0);
		chk("ef", d & 8'h32, 8'h20);
		pulse(6'h02);
		pulse(6'h0c);
		apb(0, 12'h254, 0);
		chk("soc", d & 8'h32, 0);
		// Pin change only on enabled pins
		apb(1, 12'h258, 8'h04);
		pins <= 8'h08;
		repeat (5) @(posedge pclk);
		chk("p3", fl[1], 0);
		chk("wk0", wakes, 0);
		pins <= 8'h0c;
		repeat (5) @(posedge pclk);
		chk("p2", fl[1], 1);
		apb(1, 12'h254, 8'hfd);
		repeat (2) @(posedge pclk);
		chk("fd", fl[1], 0);
		pins <= 8'h00;
		repeat (5) @(posedge pclk);
		chk("p2b", fl[1], 1);
		pulse(6'h10);
		repeat (2) @(posedge pclk);
		chk("ack", fl[1], 0);
		chk("wake", wakes, 2);
		// Low-voltage bit ignores writes
		lv[1] <= 1;
		repeat (8) @(posedge pclk);
		apb(1, 12'h254, 0);
		apb(0, 12'h254, 0);
		chk("lv", d & 8'h80, 8'h80);
		// Unlock, lock gating, timeout bit
		apb(1, 12'h25c, 8'h65);
		apb(0, 12'h25c, 0);
		chk("unl", d, 1);
		chk("ulk", ul, 1);
		chk("ok", fok, 1);
		lv <= 4'hf;
		repeat (6) @(posedge pclk);
		chk("lock", fok, 0);
		apb(1, 12'h25c, 8'h56);
		apb(0, 12'h25c, 0);
		chk("wdog_timeout_flag", d, 2);
		chk("ulk0", ul, 0);
		repeat (3) @(posedge pclk);
		chk("srst", srh, 4);
		finish_test;
	end
endmodule
`default_nettype wire

// ### verilog/sofr_conv_clkdiv.v
// Purpose: converter clock divider, divide by 32, 16, 8 or 4
// Assumes: select comes from a register on the same clock
// Notes:   output is a registered one-cycle enable strobe
`timescale 1ns/100ps
`default_nettype none
`include "sofr_map.vh"

module sofr_conv_clkdiv (
	input  wire       pclk,
	input  wire       presetn,
	input  wire [1:0] div_sel,
	output reg        conv_clk_en_ff
);

	// Terminal counts, cut to counter width where used
	localparam [31:0] LAST_0 = `SOFR_CONV_DIV_0 - 1;
	localparam [31:0] LAST_1 = `SOFR_CONV_DIV_1 - 1;
	localparam [31:0] LAST_2 = `SOFR_CONV_DIV_2 - 1;
	localparam [31:0] LAST_3 = `SOFR_CONV_DIV_3 - 1;

	reg  [4:0] cnt_ff;
	reg  [4:0] last;

	// Terminal count per code, counts from zero
	always @* begin
		case (div_sel)
		2'b00:   last = LAST_0[4:0];
		2'b01:   last = LAST_1[4:0];
		2'b10:   last = LAST_2[4:0];
		default: last = LAST_3[4:0];
		endcase
	end

	// Counter wraps at terminal; a select change takes effect at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff         <= 5'h00;
			conv_clk_en_ff <= 1'b0;
		end else if (cnt_ff >= last) begin
			cnt_ff         <= 5'h00;
			conv_clk_en_ff <= 1'b1;
		end else begin
			cnt_ff         <= cnt_ff + 5'h01;
			conv_clk_en_ff <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ### verilog/sofr_option_regs.v
// Purpose: system option and flag register bank on APB
// Assumes: pclk 20 MHz; slow clock and event inputs come from pins
// Notes:   zero-wait APB slave, unmapped addresses read zero
//
// Behaviour
// - One-wire bit routes serial one to one pin
// - Watchdog field picks 480/240/120/60 ms
// - Converter clock divides by 32/16/8/4
// - Tick period 32768/16384/8192/128 slow cycles
// - Low-voltage flag mirrors detector, read-only
// - Touch flag set at end with fast clock, cleared
// - Converter flag set at end, cleared
// - Pin change on enabled pin sets flag
// - Pin flag cleared by service or write
// - Tick flag set at selected period
// - Tick flag cleared by service or write
// - Wake-enable bits gate each port pin
// - Writing 56h requests soft reset
// - 65h sets unlock, other value clears
// - Command read shows unlock and timeout
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "sofr_map.vh"

module sofr_option_regs #(
	parameter CLK_HZ    = 20000000,
	parameter WDOG_DIV  = 1000
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata_ff,
	output wire        pready,
	output wire        pslverr,
	input  wire        slow_clk,
	input  wire [7:0]  port_one_pins,
	input  wire        low_volt_det,
	input  wire        touch_end,
	input  wire        touch_fast_ok,
	input  wire        touch_start_bit,
	input  wire        conv_end,
	input  wire        conv_start_bit,
	input  wire        pin_change_ack,
	input  wire        tick_ack,
	input  wire        wdog_timeout,
	input  wire        program_area_lock,
	output reg         one_wire_serial_sel_ff,
	output reg  [1:0]  wdog_period_sel_ff,
	output reg  [1:0]  conv_clock_div_sel_ff,
	output reg  [1:0]  tick_rate_sel_ff,
	output wire        conv_clk_en,
	output reg         wake_req_ff,
	output reg         soft_reset_ff,
	output reg         self_program_unlock_ff,
	output reg         flash_write_ok_ff,
	output reg         wdog_expire_ff,
	output reg  [7:0]  flags_out_ff
);

	// Watchdog base: counts core cycles per ms, then ms per period
	localparam [31:0] CYC_PER_MS = CLK_HZ / 1000;
	// Terminal counts, cut to counter width where used
	localparam [31:0] TICK_L0  = `SOFR_TICK_CYC_0 - 1;
	localparam [31:0] TICK_L1  = `SOFR_TICK_CYC_1 - 1;
	localparam [31:0] TICK_L2  = `SOFR_TICK_CYC_2 - 1;
	localparam [31:0] TICK_L3  = `SOFR_TICK_CYC_3 - 1;
	localparam [31:0] WDOG_L0  = `SOFR_WDOG_MS_0 - 1;
	localparam [31:0] WDOG_L1  = `SOFR_WDOG_MS_1 - 1;
	localparam [31:0] WDOG_L2  = `SOFR_WDOG_MS_2 - 1;
	localparam [31:0] WDOG_L3  = `SOFR_WDOG_MS_3 - 1;
	localparam [31:0] SRST_LEN = `SOFR_SRST_CYC;

	reg  [7:0]  wake_en_ff;
	reg  [7:0]  flags_ff;
	reg  [7:0]  nxt_flags;
	reg  [7:0]  p1_s0_ff;
	reg  [7:0]  p1_s1_ff;
	reg  [7:0]  p1_old_ff;
	reg  [2:0]  ev_s0_ff;
	reg  [2:0]  ev_s1_ff;
	reg         slow_old_ff;
	reg  [14:0] tick_cnt_ff;
	reg  [2:0]  srst_cnt_ff;
	reg  [31:0] ms_pre_ff;
	reg  [8:0]  ms_cnt_ff;
	reg         wdog_timeout_flag_ff;
	reg  [14:0] tick_last;
	reg  [8:0]  wdog_last;
	reg  [31:0] rdata;
	wire        wr;
	wire        rd;
	wire        slow_rise;
	wire        tick_hit;
	wire        pin_hit;
	wire        wr_flags;
	wire        wr_cmd;

	// Address compare used for every register
	function hit;
		input [11:0] a;
		input [11:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// Zero-wait slave: every access completes in its first access cycle
	assign pready   = 1'b1;
	assign pslverr  = 1'b0;
	assign wr       = psel & penable & pwrite & pstrb[0];
	assign rd       = psel & ~penable & ~pwrite;
	assign wr_flags = wr & hit(paddr, `SOFR_ADDR_FLAGS);
	assign wr_cmd   = wr & hit(paddr, `SOFR_ADDR_CMD);

	// Two-flop synchronisers for pins and slow clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_s0_ff    <= 8'h00;
			p1_s1_ff    <= 8'h00;
			p1_old_ff   <= 8'h00;
			ev_s0_ff    <= 3'h0;
			ev_s1_ff    <= 3'h0;
			slow_old_ff <= 1'b0;
		end else begin
			p1_s0_ff    <= port_one_pins;
			p1_s1_ff    <= p1_s0_ff;
			p1_old_ff   <= p1_s1_ff;
			ev_s0_ff    <= {low_volt_det, wdog_timeout, slow_clk};
			ev_s1_ff    <= ev_s0_ff;
			slow_old_ff <= ev_s1_ff[0];
		end
	end

	assign slow_rise = ev_s1_ff[0] & ~slow_old_ff;
	// Change on enabled pin; per-pin gate
	assign pin_hit   = |((p1_s1_ff ^ p1_old_ff) & wake_en_ff);

	// Tick terminal count per rate code
	always @* begin
		case (tick_rate_sel_ff)
		2'b00:   tick_last = TICK_L0[14:0];
		2'b01:   tick_last = TICK_L1[14:0];
		2'b10:   tick_last = TICK_L2[14:0];
		default: tick_last = TICK_L3[14:0];
		endcase
	end

	assign tick_hit = slow_rise & (tick_cnt_ff >= tick_last);

	// Tick timer counts slow-clock rising edges
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= 15'h0000;
		end else if (tick_hit) begin
			tick_cnt_ff <= 15'h0000;
		end else if (slow_rise) begin
			tick_cnt_ff <= tick_cnt_ff + 15'h0001;
		end
	end

	// Watchdog period in ms per code
	always @* begin
		case (wdog_period_sel_ff)
		2'b00:   wdog_last = WDOG_L0[8:0];
		2'b01:   wdog_last = WDOG_L1[8:0];
		2'b10:   wdog_last = WDOG_L2[8:0];
		default: wdog_last = WDOG_L3[8:0];
		endcase
	end

	// Watchdog interval marker; kicking is outside this bank
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_pre_ff      <= 32'h00000000;
			ms_cnt_ff      <= 9'h000;
			wdog_expire_ff <= 1'b0;
		end else if (ms_pre_ff >= CYC_PER_MS - 32'h1) begin
			ms_pre_ff <= 32'h00000000;
			if (ms_cnt_ff >= wdog_last) begin
				ms_cnt_ff      <= 9'h000;
				wdog_expire_ff <= 1'b1;
			end else begin
				ms_cnt_ff      <= ms_cnt_ff + 9'h001;
				wdog_expire_ff <= 1'b0;
			end
		end else begin
			ms_pre_ff      <= ms_pre_ff + 32'h1;
			wdog_expire_ff <= 1'b0;
		end
	end

	// Flag next state: clears first, so a same-cycle set wins
	always @* begin
		nxt_flags = flags_ff;
		if (wr_flags) begin
			nxt_flags[`SOFR_FLG_TOUCH] = flags_ff[`SOFR_FLG_TOUCH]
				& pwdata[`SOFR_FLG_TOUCH];
			nxt_flags[`SOFR_FLG_CONV]  = flags_ff[`SOFR_FLG_CONV]
				& pwdata[`SOFR_FLG_CONV];
			nxt_flags[`SOFR_FLG_PIN]   = flags_ff[`SOFR_FLG_PIN]
				& pwdata[`SOFR_FLG_PIN];
			nxt_flags[`SOFR_FLG_TICK]  = flags_ff[`SOFR_FLG_TICK]
				& pwdata[`SOFR_FLG_TICK];
		end
		if (touch_start_bit)
			nxt_flags[`SOFR_FLG_TOUCH] = 1'b0;
		if (conv_start_bit)
			nxt_flags[`SOFR_FLG_CONV] = 1'b0;
		if (pin_change_ack)
			nxt_flags[`SOFR_FLG_PIN] = 1'b0;
		if (tick_ack)
			nxt_flags[`SOFR_FLG_TICK] = 1'b0;
		if (touch_end & touch_fast_ok)
			nxt_flags[`SOFR_FLG_TOUCH] = 1'b1;
		if (conv_end)
			nxt_flags[`SOFR_FLG_CONV] = 1'b1;
		if (pin_hit)
			nxt_flags[`SOFR_FLG_PIN] = 1'b1;
		if (tick_hit)
			nxt_flags[`SOFR_FLG_TICK] = 1'b1;
		nxt_flags[`SOFR_FLG_LOWV] = ev_s1_ff[2];
		nxt_flags[6] = 1'b0;
		nxt_flags[3] = 1'b0;
		nxt_flags[2] = 1'b0;
	end

	// Software-visible registers and command effects
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			one_wire_serial_sel_ff <= 1'b0;
			wdog_period_sel_ff     <= 2'b00;
			conv_clock_div_sel_ff  <= 2'b00;
			tick_rate_sel_ff       <= 2'b00;
			wake_en_ff             <= `SOFR_RST_WAKE;
			flags_ff               <= 8'h00;
			flags_out_ff           <= 8'h00;
			self_program_unlock_ff <= 1'b0;
			flash_write_ok_ff      <= 1'b0;
			wdog_timeout_flag_ff                <= 1'b0;
			srst_cnt_ff            <= 3'h0;
			soft_reset_ff          <= 1'b0;
			wake_req_ff            <= 1'b0;
		end else begin
			flags_ff     <= nxt_flags;
			flags_out_ff <= nxt_flags;
			wake_req_ff  <= pin_hit;
			if (wr & hit(paddr, `SOFR_ADDR_MISC)) begin
				one_wire_serial_sel_ff <= pwdata[`SOFR_MISC_ONEWIRE];
				wdog_period_sel_ff     <= pwdata[5:4];
				conv_clock_div_sel_ff  <= pwdata[3:2];
				tick_rate_sel_ff       <= pwdata[1:0];
			end
			if (wr & hit(paddr, `SOFR_ADDR_WAKE))
				wake_en_ff <= pwdata[7:0];
			// Unlock set by code, else cleared
			if (wr_cmd)
				self_program_unlock_ff <=
					(pwdata[7:0] == `SOFR_CODE_UNLOCK);
			// Unlock without area lock grants access
			flash_write_ok_ff <= self_program_unlock_ff &
				~program_area_lock;
			// Timeout flag is sticky until reset
			if (ev_s1_ff[1])
				wdog_timeout_flag_ff <= 1'b1;
			// Soft reset pulse on code write
			if (wr_cmd & (pwdata[7:0] == `SOFR_CODE_RESET)) begin
				srst_cnt_ff   <= SRST_LEN[2:0];
				soft_reset_ff <= 1'b1;
			end else if (srst_cnt_ff != 3'h0) begin
				srst_cnt_ff   <= srst_cnt_ff - 3'h1;
				soft_reset_ff <= (srst_cnt_ff != 3'h1);
			end else begin
				soft_reset_ff <= 1'b0;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		rdata = 32'h00000000;
		if (hit(paddr, `SOFR_ADDR_MISC))
			rdata[7:0] = {one_wire_serial_sel_ff, 1'b0,
				wdog_period_sel_ff, conv_clock_div_sel_ff,
				tick_rate_sel_ff};
		else if (hit(paddr, `SOFR_ADDR_FLAGS))
			rdata[7:0] = flags_ff;
		else if (hit(paddr, `SOFR_ADDR_WAKE))
			rdata[7:0] = wake_en_ff;
		else if (hit(paddr, `SOFR_ADDR_CMD))
			rdata[7:0] = {6'h00, wdog_timeout_flag_ff, self_program_unlock_ff};
	end

	// Read data captured in setup, stable through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h00000000;
		else if (rd)
			prdata_ff <= rdata;
	end

	sofr_conv_clkdiv u_div (
		.pclk           (pclk),
		.presetn        (presetn),
		.div_sel        (conv_clock_div_sel_ff),
		.conv_clk_en_ff (conv_clk_en)
	);

endmodule

`default_nettype wire
